// ---- rtl/rtyq_pkg.sv ----
// Purpose: Shared constants for the RGB to 4:2:2 luma/chroma quantizer
// Assumes: 8-bit digital primaries, one sample clock
// Notes: Coefficients are integers over 256, rounding adds half an LSB
//
// Functional notes
// - Outputs are unsigned 8-bit words on a uniform 0..255 scale.
// - Codes 0 and 255 never carry picture values; only 1..254.
// - Luma code is 219 times normalised luma plus 16, rounded.
// - Chroma code is 224 times renormalised difference plus 128, rounded.
// - Digital primaries are integer part of 219 times value, plus 16.
// - Luma equals (77 R + 150 G + 29 B) / 256.
// - Red difference is (131 R - 110 G - 21 B) / 256 plus 128.
// - Blue difference is (-44 R - 87 G + 131 B) / 256 plus 128.
// - Chroma is low-pass filtered then decimated; luma stays full rate.
// - Decimation filter is symmetric, linear phase, no group-delay distortion.
// - Filter amplitude response is skew-symmetric about half-amplitude point.
// - Each chroma channel carries half the luma samples per line.
`default_nettype none

package rtyq_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam logic [7:0] PRIM_MIN = 8'h10;
    localparam logic [7:0] PRIM_MAX = 8'hEB;
    localparam logic [7:0] CODE_MIN = 8'h01;
    localparam logic [7:0] CODE_MAX = 8'hFE;
    localparam logic [7:0] CHROMA_ZERO = 8'h80;
    localparam logic signed [18:0] Y_KR = 19'sd77;
    localparam logic signed [18:0] Y_KG = 19'sd150;
    localparam logic signed [18:0] Y_KB = 19'sd29;
    localparam logic signed [18:0] CR_KR = 19'sd131;
    localparam logic signed [18:0] CR_KG = 19'sd110;
    localparam logic signed [18:0] CR_KB = 19'sd21;
    localparam logic signed [18:0] CB_KR = 19'sd44;
    localparam logic signed [18:0] CB_KG = 19'sd87;
    localparam logic signed [18:0] CB_KB = 19'sd131;
    localparam logic signed [18:0] CHROMA_OFS = 19'sd32768;
    localparam logic signed [18:0] MAT_ROUND = 19'sd128;
    localparam int unsigned MAT_SHIFT = 8;
    localparam int unsigned FIR_TAPS = 7;
    localparam int unsigned FIR_MID = 3;
    localparam logic signed [15:0] FIR_OUTER = 16'sd1;
    localparam logic signed [15:0] FIR_INNER = 16'sd9;
    localparam logic signed [15:0] FIR_CENTER = 16'sd16;
    localparam logic signed [15:0] FIR_ROUND = 16'sd16;
    localparam int unsigned FIR_SHIFT = 5;
endpackage : rtyq_pkg

`default_nettype wire

// ---- rtl/rtyq_fifo.sv ----
// Purpose: Stream FIFO with registered output word and registered ready
// Assumes: DEPTH is a power of two
// Notes: Holds up to DEPTH words plus one in the output register
`default_nettype none

module rtyq_fifo
#(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 32
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = (cnt_q != '0) && (!out_valid || out_ready);

    always_comb
    begin
        cnt_d = cnt_q;
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            // Ready is a flop so the source never sees a combinational path
            in_ready <= (cnt_d < (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (pop)
        begin
            out_valid <= 1'b1;
            out_data <= mem_q[rd_q];
        end
        else if (out_ready)
        begin
            out_valid <= 1'b0;
        end
    end
endmodule : rtyq_fifo

`default_nettype wire

// ---- rtl/rtyq_quant.sv ----
// Purpose: RGB primaries to quantized luma and 4:2:2 chroma stream
// Assumes: Primaries arrive as 8-bit digital words, in_sol marks line start
// Notes: Pipeline moves only when a sample is accepted, so latency is
//        counted in samples; output words pair Cb then Cr with two lumas
`default_nettype none

module rtyq_quant
    import rtyq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic in_sol,
    input wire logic [DATA_W-1:0] in_r,
    input wire logic [DATA_W-1:0] in_g,
    input wire logic [DATA_W-1:0] in_b,
    output logic in_ready,
    output logic out_valid,
    output logic [DATA_W-1:0] out_y,
    output logic [DATA_W-1:0] out_c,
    output logic out_c_is_cr,
    input wire logic out_ready
);
    localparam int unsigned WORD_W = 2 * DATA_W + 1;

    function automatic logic [7:0] clip_code(input logic signed [18:0] v);
        if (v < $signed({11'h000, CODE_MIN}))
        begin
            return CODE_MIN;
        end
        else if (v > $signed({11'h000, CODE_MAX}))
        begin
            return CODE_MAX;
        end
        return v[7:0];
    endfunction : clip_code

    // Round half up, then keep sync codes out of the picture
    function automatic logic [7:0] quant(input logic signed [18:0] acc);
        logic signed [18:0] t;
        t = (acc + MAT_ROUND) >>> MAT_SHIFT;
        return clip_code(t);
    endfunction : quant

    function automatic logic [7:0] clip_prim(input logic [7:0] v);
        if (v < PRIM_MIN)
        begin
            return PRIM_MIN;
        end
        else if (v > PRIM_MAX)
        begin
            return PRIM_MAX;
        end
        return v;
    endfunction : clip_prim

    // Half-band taps -1 0 9 16 9 0 -1 over 32: symmetric and skew-symmetric
    function automatic logic [7:0] fir(input logic [7:0] t0, input logic [7:0] t2,
                                       input logic [7:0] t3, input logic [7:0] t4,
                                       input logic [7:0] t6);
        logic signed [15:0] s;
        s = FIR_INNER * ($signed({8'h00, t2}) + $signed({8'h00, t4}))
            + FIR_CENTER * $signed({8'h00, t3})
            - FIR_OUTER * ($signed({8'h00, t0}) + $signed({8'h00, t6}))
            + FIR_ROUND;
        s = s >>> FIR_SHIFT;
        return clip_code(19'(s));
    endfunction : fir

    logic adv;
    logic s1_vld_q;
    logic s1_sol_q;
    logic [7:0] s1_r_q;
    logic [7:0] s1_g_q;
    logic [7:0] s1_b_q;
    logic signed [18:0] rs;
    logic signed [18:0] gs;
    logic signed [18:0] bs;
    logic s2_vld_q;
    logic s2_sol_q;
    logic [7:0] s2_y_q;
    logic [7:0] s2_cb_q;
    logic [7:0] s2_cr_q;
    logic [7:0] cb_tap_q [FIR_TAPS];
    logic [7:0] cr_tap_q [FIR_TAPS];
    logic [7:0] y_dly_q [FIR_MID+1];
    logic vld_dly_q [FIR_MID+1];
    logic sol_dly_q [FIR_MID+1];
    logic phase_q;
    logic cur_phase;
    logic [7:0] cr_hold_q;
    logic [7:0] cb_filt;
    logic [7:0] cr_filt;
    logic push;
    logic [DATA_W-1:0] push_c;
    logic fifo_ready;
    logic [WORD_W-1:0] fifo_out;

    assign adv = in_valid && in_ready;
    assign rs = $signed({11'h000, s1_r_q});
    assign gs = $signed({11'h000, s1_g_q});
    assign bs = $signed({11'h000, s1_b_q});

    // Stage 1: primaries held to the legal 16..235 digital range
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_vld_q <= 1'b0;
            s1_sol_q <= 1'b0;
            s1_r_q <= PRIM_MIN;
            s1_g_q <= PRIM_MIN;
            s1_b_q <= PRIM_MIN;
        end
        else if (adv)
        begin
            s1_vld_q <= 1'b1;
            s1_sol_q <= in_sol;
            s1_r_q <= clip_prim(in_r);
            s1_g_q <= clip_prim(in_g);
            s1_b_q <= clip_prim(in_b);
        end
    end

    // Stage 2: base-256 matrix, rounding to nearest code
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s2_vld_q <= 1'b0;
            s2_sol_q <= 1'b0;
            s2_y_q <= PRIM_MIN;
            s2_cb_q <= CHROMA_ZERO;
            s2_cr_q <= CHROMA_ZERO;
        end
        else if (adv)
        begin
            s2_vld_q <= s1_vld_q;
            s2_sol_q <= s1_sol_q;
            s2_y_q <= quant(Y_KR * rs + Y_KG * gs + Y_KB * bs);
            s2_cr_q <= quant(CR_KR * rs - CR_KG * gs - CR_KB * bs + CHROMA_OFS);
            s2_cb_q <= quant(CB_KB * bs - CB_KR * rs - CB_KG * gs + CHROMA_OFS);
        end
    end

    // Stage 3: chroma tap lines; luma delayed by the filter's centre delay
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < FIR_TAPS; i++)
            begin
                cb_tap_q[i] <= CHROMA_ZERO;
                cr_tap_q[i] <= CHROMA_ZERO;
            end
            for (int i = 0; i <= FIR_MID; i++)
            begin
                y_dly_q[i] <= PRIM_MIN;
                vld_dly_q[i] <= 1'b0;
                sol_dly_q[i] <= 1'b0;
            end
        end
        else if (adv)
        begin
            cb_tap_q[0] <= s2_cb_q;
            cr_tap_q[0] <= s2_cr_q;
            y_dly_q[0] <= s2_y_q;
            vld_dly_q[0] <= s2_vld_q;
            sol_dly_q[0] <= s2_sol_q;
            for (int i = 1; i < FIR_TAPS; i++)
            begin
                cb_tap_q[i] <= cb_tap_q[i-1];
                cr_tap_q[i] <= cr_tap_q[i-1];
            end
            for (int i = 1; i <= FIR_MID; i++)
            begin
                y_dly_q[i] <= y_dly_q[i-1];
                vld_dly_q[i] <= vld_dly_q[i-1];
                sol_dly_q[i] <= sol_dly_q[i-1];
            end
        end
    end

    // Taps run across line ends; edge pixels see the neighbour line's chroma
    assign cb_filt = fir(cb_tap_q[0], cb_tap_q[2], cb_tap_q[3], cb_tap_q[4], cb_tap_q[6]);
    assign cr_filt = fir(cr_tap_q[0], cr_tap_q[2], cr_tap_q[3], cr_tap_q[4], cr_tap_q[6]);

    // Decimation: even sample sends Cb, odd sends the Cr of the even sample
    assign push = adv && vld_dly_q[FIR_MID];
    assign cur_phase = sol_dly_q[FIR_MID] ? 1'b0 : phase_q;
    assign push_c = cur_phase ? cr_hold_q : cb_filt;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_q <= 1'b0;
            cr_hold_q <= CHROMA_ZERO;
        end
        else if (push)
        begin
            phase_q <= ~cur_phase;
            if (!cur_phase)
            begin
                cr_hold_q <= cr_filt;
            end
        end
    end

    rtyq_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_data({cur_phase, push_c, y_dly_q[FIR_MID]}),
        .in_ready(fifo_ready),
        .out_valid(out_valid),
        .out_data(fifo_out),
        .out_ready(out_ready)
    );

    // Back-pressure stalls every stage, so nothing is dropped in the pipe
    assign in_ready = fifo_ready;
    assign out_y = fifo_out[DATA_W-1:0];
    assign out_c = fifo_out[2*DATA_W-1:DATA_W];
    assign out_c_is_cr = fifo_out[WORD_W-1];

    logic last_sel_q;
    logic red_in;
    logic grey_in;
    logic cb_flat;

    assign red_in = adv && s1_vld_q && s1_r_q == PRIM_MAX && s1_g_q == PRIM_MIN
                    && s1_b_q == PRIM_MIN;
    assign grey_in = adv && s1_vld_q && s1_r_q == s1_g_q && s1_g_q == s1_b_q;
    assign cb_flat = cb_tap_q[0] == cb_tap_q[3] && cb_tap_q[2] == cb_tap_q[3]
                     && cb_tap_q[4] == cb_tap_q[3] && cb_tap_q[6] == cb_tap_q[3];

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_sel_q <= 1'b1;
        end
        else if (push)
        begin
            last_sel_q <= cur_phase;
        end
    end

    default clocking cb_main @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_prim_range: assert property (
        s1_vld_q |-> s1_r_q >= PRIM_MIN && s1_r_q <= PRIM_MAX && s1_b_q <= PRIM_MAX)
        else $error("primary outside 16..235");
    a_black_luma: assert property (
        adv && s1_vld_q && s1_r_q == PRIM_MIN && s1_g_q == PRIM_MIN && s1_b_q == PRIM_MIN
        |=> s2_y_q == 8'h10)
        else $error("black does not give luma 16");
    a_grey_chroma: assert property (
        grey_in |=> s2_cb_q == CHROMA_ZERO && s2_cr_q == CHROMA_ZERO)
        else $error("grey does not give chroma 128");
    a_white_luma: assert property (
        adv && s1_vld_q && s1_r_q == PRIM_MAX && s1_g_q == PRIM_MAX && s1_b_q == PRIM_MAX
        |=> s2_y_q == 8'hEB)
        else $error("white does not give luma 235");
    a_red_cr: assert property (
        red_in |=> s2_cr_q == 8'hF0)
        else $error("red does not give Cr 240");
    a_red_cb: assert property (
        red_in |=> s2_cb_q == 8'h5A)
        else $error("red does not give Cb 90");
    a_code_range: assert property (
        out_valid |-> out_y inside {[CODE_MIN:CODE_MAX]} && out_c inside {[CODE_MIN:CODE_MAX]})
        else $error("reserved code on output");
    a_chroma_alt: assert property (
        push && !sol_dly_q[FIR_MID] |-> cur_phase != last_sel_q)
        else $error("chroma pairing broken");
    a_flat_filter: assert property (
        push && !cur_phase && cb_flat && cb_tap_q[3] inside {[CODE_MIN:CODE_MAX]}
        |-> push_c == cb_tap_q[3])
        else $error("filter DC gain not unity");
    a_stall_hold: assert property (
        !in_ready && s2_vld_q |=> $stable(s2_y_q) && $stable(y_dly_q[FIR_MID]))
        else $error("pipeline moved while stalled");

    c_red_seen: cover property (red_in ##1 s2_vld_q);
    c_cr_word: cover property (out_valid && out_ready && out_c_is_cr);
    c_fifo_full: cover property (s2_vld_q && !in_ready ##1 in_ready);
    c_line_start: cover property (push && sol_dly_q[FIR_MID]);
endmodule : rtyq_quant

`default_nettype wire

// ---- tb/rtyq_sink_model.sv ----
// Purpose: Downstream 4:2:2 consumer with selectable back-pressure
// Assumes: Mode 0 always ready, 1 stalled, 2 ready every other cycle
// Notes: Ready moves only at the falling edge, away from the sampling edge
`default_nettype none

module rtyq_sink_model
(
    input wire logic sys_clk,
    input wire logic [1:0] mode,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q = 1'b0;
    always @(negedge sys_clk)
    begin
        tog_q <= ~tog_q;
        out_ready <= (mode == 2'h0) || ((mode == 2'h2) && tog_q);
    end
endmodule : rtyq_sink_model

`default_nettype wire

// ---- tb/rtyq_quant_tb.sv ----
// Purpose: Self-checking bench for the RGB to 4:2:2 quantizer
// Assumes: Source driven at the falling edge, one reset at start
// Notes: Reference filters full-rate chroma; taps before the first sample are 128
`default_nettype none

module rtyq_quant_tb
    import rtyq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk;
    logic rst_n;
    logic in_valid;
    logic in_sol;
    logic [7:0] in_r;
    logic [7:0] in_g;
    logic [7:0] in_b;
    logic in_ready;
    logic out_valid;
    logic [7:0] out_y;
    logic [7:0] out_c;
    logic out_c_is_cr;
    logic out_ready;
    logic [1:0] mode;
    int fail_count;
    int compares;
    int sent;
    int got;
    int phase;
    int ey[256];
    int ecb[256];
    int ecr[256];
    int eph[256];

    rtyq_quant i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .in_valid(in_valid),
        .in_sol(in_sol), .in_r(in_r), .in_g(in_g), .in_b(in_b), .in_ready(in_ready),
        .out_valid(out_valid), .out_y(out_y), .out_c(out_c),
        .out_c_is_cr(out_c_is_cr), .out_ready(out_ready));
    rtyq_sink_model i_sink (.sys_clk(sys_clk), .mode(mode), .out_ready(out_ready));

    function automatic int clip(input int v, input int lo, input int hi);
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clip

    // Taps -1,0,9,16,9,0,-1 over 32, symmetric so no delay distortion
    function automatic int filt(input int k, input bit cr);
        int acc;
        int c[7];
        for (int j = 0; j < 7; j++)
        begin
            c[j] = (k - 3 + j < 0) ? 128 : (cr ? ecr[k - 3 + j] : ecb[k - 3 + j]);
        end
        acc = 16 * c[3] + 9 * (c[2] + c[4]) - c[0] - c[6];
        filt = clip((acc + 16) >>> 5, 1, 254);
    endfunction : filt

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t word %0d got %h expected %h", $time, got, g, e);
        end
    endtask : chk8

    task automatic chk1(input logic g, input logic e);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t flag got %b expected %b", $time, g, e);
        end
    endtask : chk1

    task automatic chk_int(input int g, input int e);
        compares++;
        if (g != e)
        begin
            fail_count++;
            $display("[FAIL] %0t count got %0d expected %0d", $time, g, e);
        end
    endtask : chk_int

    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // Holds the sample until ready is seen; gives up after 20 cycles
    task automatic send(input int r, input int g, input int b, input bit sol, output bit ok);
        int w;
        int pr;
        int pg;
        int pb;
        @(negedge sys_clk);
        in_valid = 1'b1;
        in_sol = sol;
        in_r = r[7:0];
        in_g = g[7:0];
        in_b = b[7:0];
        w = 0;
        while (in_ready !== 1'b1 && w < 20)
        begin
            @(negedge sys_clk);
            w++;
        end
        ok = (in_ready === 1'b1);
        if (ok)
        begin
            pr = clip(r, 16, 235);
            pg = clip(g, 16, 235);
            pb = clip(b, 16, 235);
            phase = sol ? 0 : phase + 1;
            ey[sent] = clip((77 * pr + 150 * pg + 29 * pb + 128) >>> 8, 1, 254);
            ecr[sent] = clip(((131 * pr - 110 * pg - 21 * pb + 128) >>> 8) + 128, 1, 254);
            ecb[sent] = clip(((-44 * pr - 87 * pg + 131 * pb + 128) >>> 8) + 128, 1, 254);
            eph[sent] = phase;
            sent++;
        end
    endtask : send

    task automatic idle();
        @(negedge sys_clk);
        in_valid = 1'b0;
        in_sol = 1'b0;
    endtask : idle

    task automatic wait_out(input int n, input int lim);
        int w;
        w = 0;
        while (got < n && w < lim)
        begin
            @(posedge sys_clk);
            w++;
        end
        #1;
        chk_int(got, n);
    endtask : wait_out

    always @(posedge sys_clk)
    begin
        if (rst_n && out_valid && out_ready)
        begin
            chk8(out_y, 8'(ey[got]));
            chk8(out_c, 8'((eph[got] % 2) ? filt(got - 1, 1) : filt(got, 0)));
            chk1(out_c_is_cr, 1'(eph[got] % 2));
            chk1((out_y >= CODE_MIN) && (out_y <= CODE_MAX) && (out_c >= CODE_MIN)
                && (out_c <= CODE_MAX), 1'b1);
            got++;
        end
    end

    // Six samples fill the pipe; the first word needs a seventh sample to move it out
    task automatic t_latency();
        bit ok;
        for (int i = 0; i < 6; i++)
        begin
            send(128 + i, 64, 200, i == 0, ok);
        end
        idle();
        repeat (10) @(negedge sys_clk);
        chk1(out_valid, 1'b0);
        send(40, 220, 90, 1'b0, ok);
        idle();
        wait_out(1, 6);
    endtask : t_latency

    task automatic t_colours();
        int rt[11] = '{16, 235, 235, 16, 16, 235, 16, 235, 0, 255, 128};
        int gt[11] = '{16, 235, 16, 235, 16, 235, 235, 16, 0, 255, 90};
        int bt[11] = '{16, 235, 16, 16, 235, 16, 235, 235, 0, 255, 30};
        bit ok;
        mode = 2'h0;
        for (int c = 0; c < 11; c++)
        begin
            for (int i = 0; i < 6; i++)
            begin
                send(rt[c], gt[c], bt[c], i == 0, ok);
            end
        end
        idle();
        wait_out(sent - 6, 200);
    endtask : t_colours

    // A lone yellow pixel on black shows the filter's impulse response
    task automatic t_impulse();
        bit ok;
        mode = 2'h2;
        for (int i = 0; i < 12; i++)
        begin
            send(i == 6 ? 235 : 16, i == 6 ? 235 : 16, i == 6 ? 16 : 16, i == 0, ok);
        end
        send(16, 16, 235, 1'b1, ok);
        for (int i = 0; i < 6; i++)
        begin
            send(235 - 20 * i, 16 + 30 * i, 100, i == 6, ok);
        end
        idle();
        wait_out(sent - 6, 200);
    endtask : t_impulse

    task automatic t_fill();
        bit ok;
        int n;
        mode = 2'h1;
        n = 0;
        ok = 1'b1;
        while (ok && n < 60)
        begin
            send((n * 7) % 256, (n * 13) % 256, 255 - n, n == 0, ok);
            n += int'(ok);
        end
        idle();
        chk_int(n, FIFO_DEPTH + 1);
        mode = 2'h2;
        wait_out(sent - 6, 400);
    endtask : t_fill

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        rst_n = 1'b0;
        in_valid = 1'b0;
        in_sol = 1'b0;
        in_r = 8'h00;
        in_g = 8'h00;
        in_b = 8'h00;
        mode = 2'h0;
        fail_count = 0;
        compares = 0;
        sent = 0;
        got = 0;
        phase = 0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        t_latency();
        t_colours();
        t_impulse();
        t_fill();
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule : rtyq_quant_tb

`default_nettype wire
